/* File: ucbg_top.sv */
// serial control register, data register, baud generator, AXI4-Lite slave
// Notes on behaviour
// - clearing tx_enable aborts transmission, empties buffer, floats TX
// - transmitter runs and drives TX only with both enables set
// - clearing rx_enable aborts reception, resets receive buffer, frees RX
// - receiver runs and owns RX only with both enables set
// - baud rate is fH/(64(N+1)) low speed, fH/(16(N+1)) high speed
// - bits timed by free-running 8-bit counter, period from N 0..255
// - with address detect, word is address when its address bit is 1
// - address words raise an interrupt request when enabled
// - with address detect, words with address bit 0 are discarded silently
// - wake enabled and fH stopped: RX falling edge raises wake request
// - no RX wake-up while fH runs
// - wake disabled and fH stopped: RX falling edge does nothing
// - rx irq enable lets overrun or data-available set the request flag
// - tx idle irq enable lets tx idle set the request flag
// - tx empty irq enable lets tx buffer empty set the request flag
// - one data location: write feeds transmitter, read gives last received
// - second control register is zero at power-on
// - clearing function enable floats pins, empties buffers, resets rx flags but not wake or request flags
// - nine_bit_select picks 8 or 9 bit frames, ninth bits held apart
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
module ucbg_top (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [ucbg_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ucbg_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic TX_OUT,
  output logic TX_OE,
  input wire logic RX_IN,
  output logic RX_ACTIVE,
  input wire logic FH_STOPPED,
  output logic IRQ_REQ
);
  // ---------------------------------------------------------------
  // registers and declarations
  // ---------------------------------------------------------------
  logic [7:0] line_q, ctrl2_q, baud_div_q, tx_buf_q, rx_data_q;
  logic tx_full_q, rx_avail_q, overrun_q, rx_nine_q, wake_q, irq_q;
  logic tx_en_d1_q, rx_en_d1_q;
  logic prev_idle_q, prev_empty_q, prev_avail_q, prev_ovr_q, prev_wake_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ucbg_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
  logic [7:0] brg_cnt_q;
  ucbg_pkg::ucbg_tx_e tx_state_q;
  ucbg_pkg::ucbg_rx_e rx_state_q;
  logic [8:0] tx_shift_q, rx_shift_q;
  logic [3:0] tx_bit_q, rx_bit_q;
  logic [6:0] tx_sub_q, rx_sub_q;
  logic tx_pin_q, tx_oe_q, rx_act_q;

  logic func_en, nine, tx_run, rx_run, tick, tx_end, rx_end, rx_half;
  logic [6:0] tpb;
  logic [3:0] last_bit;
  logic wr_go, wr_line, wr_ctrl2, wr_data, wr_baud, wr_stat;
  logic rd_go, rd_data, rx_fall, rx_done, addr_bit, keep;
  logic tx_empty, tx_idle, wake_set, irq_set, irq_clr;

  assign func_en = line_q[ucbg_pkg::LC_FUNC_ENABLE];
  assign nine = line_q[ucbg_pkg::LC_NINE_BIT];
  assign tx_run = func_en & ctrl2_q[ucbg_pkg::C2_TX_ENABLE];
  assign rx_run = func_en & ctrl2_q[ucbg_pkg::C2_RX_ENABLE];
  assign last_bit = nine ? ucbg_pkg::LAST_BIT_NINE
                         : ucbg_pkg::LAST_BIT_EIGHT;

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  assign S_AXI_AWREADY = ~aw_hold_q & ~bvalid_q;
  assign S_AXI_WREADY = ~w_hold_q & ~bvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_line = wr_go & wstrb0_q & (awaddr_q == ucbg_pkg::OFS_LINE_CTRL);
  assign wr_ctrl2 = wr_go & wstrb0_q
                  & (awaddr_q == ucbg_pkg::OFS_CTRL_SECOND);
  assign wr_data = wr_go & wstrb0_q & (awaddr_q == ucbg_pkg::OFS_DATA_BUF);
  assign wr_baud = wr_go & wstrb0_q & (awaddr_q == ucbg_pkg::OFS_BAUD_DIV);
  assign wr_stat = wr_go & wstrb0_q & (awaddr_q == ucbg_pkg::OFS_STATUS);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= ucbg_pkg::RST_BYTE;
      wstrb0_q <= 1'b0;
      bresp_q <= ucbg_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_q <= 1'b1;
        wdata_q <= S_AXI_WDATA[7:0];
        wstrb0_q <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == ucbg_pkg::OFS_LINE_CTRL ||
                    awaddr_q == ucbg_pkg::OFS_CTRL_SECOND ||
                    awaddr_q == ucbg_pkg::OFS_DATA_BUF ||
                    awaddr_q == ucbg_pkg::OFS_BAUD_DIV ||
                    awaddr_q == ucbg_pkg::OFS_STATUS)
                   ? ucbg_pkg::RESP_OKAY : ucbg_pkg::RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign rd_go = S_AXI_ARVALID & ~rvalid_q;
  assign rd_data = rd_go & (S_AXI_ARADDR == ucbg_pkg::OFS_DATA_BUF);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ucbg_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= ucbg_pkg::RESP_OKAY;
      rdata_q <= '0;
      unique case (S_AXI_ARADDR)
        ucbg_pkg::OFS_LINE_CTRL: begin
          rdata_q[7:0] <= {line_q[7:2], rx_nine_q, 1'b0};
        end
        ucbg_pkg::OFS_CTRL_SECOND: rdata_q[7:0] <= ctrl2_q;
        ucbg_pkg::OFS_DATA_BUF: rdata_q[7:0] <= rx_data_q;
        ucbg_pkg::OFS_BAUD_DIV: rdata_q[7:0] <= baud_div_q;
        ucbg_pkg::OFS_STATUS: begin
          rdata_q[ucbg_pkg::ST_TX_EMPTY] <= tx_empty;
          rdata_q[ucbg_pkg::ST_TX_IDLE] <= tx_idle;
          rdata_q[ucbg_pkg::ST_RX_AVAIL] <= rx_avail_q;
          rdata_q[ucbg_pkg::ST_RX_IDLE] <= rx_state_q == ucbg_pkg::RX_IDLE;
          rdata_q[ucbg_pkg::ST_OVERRUN] <= overrun_q;
          rdata_q[ucbg_pkg::ST_WAKE_REQ] <= wake_q;
          rdata_q[ucbg_pkg::ST_IRQ_REQ] <= irq_q;
        end
        default: rresp_q <= ucbg_pkg::RESP_SLVERR;
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      line_q <= ucbg_pkg::RST_BYTE;
      ctrl2_q <= ucbg_pkg::RST_BYTE;
      baud_div_q <= ucbg_pkg::RST_BYTE;
      tx_en_d1_q <= 1'b0;
      rx_en_d1_q <= 1'b0;
    end else begin
      if (wr_line) line_q <= wdata_q;
      if (wr_baud) baud_div_q <= wdata_q;
      if (wr_ctrl2) ctrl2_q <= wdata_q;
      // disabling the function drops both direction enables
      if (!func_en) begin
        ctrl2_q[ucbg_pkg::C2_TX_ENABLE] <= 1'b0;
        ctrl2_q[ucbg_pkg::C2_RX_ENABLE] <= 1'b0;
      end
      tx_en_d1_q <= ctrl2_q[ucbg_pkg::C2_TX_ENABLE];
      rx_en_d1_q <= ctrl2_q[ucbg_pkg::C2_RX_ENABLE];
    end
  end

  // ---------------------------------------------------------------
  // RX pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_lvl_q <= 1'b1;
    end else begin
      rx_s1_q <= RX_IN;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) rx_lvl_q <= rx_s2_q;
    end
  end
  assign rx_fall = rx_lvl_q & (rx_s2_q == rx_s3_q) & ~rx_s2_q;

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------
  // held while fH is stopped; a stopped clock gives no ticks
  assign tick = func_en & ~FH_STOPPED & (brg_cnt_q == 8'h00);
  assign tpb = ctrl2_q[ucbg_pkg::C2_HIGH_SPEED]
             ? ucbg_pkg::TICKS_HIGH_SPEED : ucbg_pkg::TICKS_LOW_SPEED;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      brg_cnt_q <= ucbg_pkg::RST_BYTE;
    end else if (!func_en) begin
      brg_cnt_q <= baud_div_q;
    end else if (!FH_STOPPED) begin
      brg_cnt_q <= (brg_cnt_q == 8'h00) ? baud_div_q
                                        : brg_cnt_q - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  assign tx_end = tick & (tx_sub_q == tpb - 7'h01);
  assign tx_empty = ~tx_full_q;
  assign tx_idle = ~tx_full_q & (tx_state_q == ucbg_pkg::TX_IDLE);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_full_q <= 1'b0;
      tx_buf_q <= ucbg_pkg::RST_BYTE;
    end else if (!func_en || (tx_en_d1_q &&
                 !ctrl2_q[ucbg_pkg::C2_TX_ENABLE])) begin
      tx_full_q <= 1'b0;
    end else if (wr_data && !tx_full_q) begin
      tx_buf_q <= wdata_q;
      tx_full_q <= 1'b1;
    end else if (tx_run && tx_state_q == ucbg_pkg::TX_IDLE && tick) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_state_q <= ucbg_pkg::TX_IDLE;
      tx_shift_q <= '0;
      tx_bit_q <= '0;
      tx_sub_q <= '0;
    end else if (!tx_run) begin
      tx_state_q <= ucbg_pkg::TX_IDLE;
      tx_sub_q <= '0;
    end else begin
      if (tick) tx_sub_q <= tx_end ? 7'h00 : tx_sub_q + 7'h01;
      unique case (tx_state_q)
        ucbg_pkg::TX_IDLE: begin
          // start on a tick, else the start bit comes out short
          if (tx_full_q && tick) begin
            tx_shift_q <= {line_q[ucbg_pkg::LC_TX_NINTH], tx_buf_q};
            tx_state_q <= ucbg_pkg::TX_START;
            tx_sub_q <= '0;
          end
        end
        ucbg_pkg::TX_START: begin
          if (tx_end) begin
            tx_state_q <= ucbg_pkg::TX_DATA;
            tx_bit_q <= '0;
          end
        end
        ucbg_pkg::TX_DATA: begin
          if (tx_end) begin
            tx_shift_q <= {1'b0, tx_shift_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == last_bit) tx_state_q <= ucbg_pkg::TX_STOP;
          end
        end
        ucbg_pkg::TX_STOP: begin
          if (tx_end) tx_state_q <= ucbg_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_pin_q <= 1'b1;
      tx_oe_q <= 1'b0;
      rx_act_q <= 1'b0;
    end else begin
      tx_pin_q <= !(tx_run && (tx_state_q == ucbg_pkg::TX_START ||
                  (tx_state_q == ucbg_pkg::TX_DATA && !tx_shift_q[0])));
      tx_oe_q <= tx_run;
      rx_act_q <= rx_run;
    end
  end
  assign TX_OUT = tx_pin_q;
  assign TX_OE = tx_oe_q;
  assign RX_ACTIVE = rx_act_q;

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  // start bit checked at its middle, data sampled a whole bit apart
  assign rx_half = tick & (rx_sub_q == (tpb >> 1) - 7'h01);
  assign rx_end = tick & (rx_sub_q == tpb - 7'h01);
  assign rx_done = rx_end & (rx_state_q == ucbg_pkg::RX_STOP);
  assign addr_bit = nine ? rx_shift_q[8] : rx_shift_q[7];
  assign keep = ~ctrl2_q[ucbg_pkg::C2_ADDR_DETECT] | addr_bit;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_state_q <= ucbg_pkg::RX_IDLE;
      rx_shift_q <= '0;
      rx_bit_q <= '0;
      rx_sub_q <= '0;
    end else if (!rx_run) begin
      rx_state_q <= ucbg_pkg::RX_IDLE;
      rx_sub_q <= '0;
    end else begin
      if (tick) rx_sub_q <= rx_end ? 7'h00 : rx_sub_q + 7'h01;
      unique case (rx_state_q)
        ucbg_pkg::RX_IDLE: begin
          if (rx_fall) begin
            rx_state_q <= ucbg_pkg::RX_START;
            rx_shift_q <= '0;
            rx_sub_q <= '0;
          end
        end
        ucbg_pkg::RX_START: begin
          if (rx_half) begin
            rx_sub_q <= '0;
            rx_bit_q <= '0;
            rx_state_q <= rx_lvl_q ? ucbg_pkg::RX_IDLE : ucbg_pkg::RX_DATA;
          end
        end
        ucbg_pkg::RX_DATA: begin
          if (rx_end) begin
            rx_shift_q[rx_bit_q] <= rx_lvl_q;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == last_bit) rx_state_q <= ucbg_pkg::RX_STOP;
          end
        end
        ucbg_pkg::RX_STOP: begin
          if (rx_end) rx_state_q <= ucbg_pkg::RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_avail_q <= 1'b0;
      overrun_q <= 1'b0;
      rx_data_q <= ucbg_pkg::RST_BYTE;
      rx_nine_q <= 1'b0;
    end else if (!rx_run) begin
      rx_avail_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (rx_done && keep) begin
      // a new word in the read cycle still lands, set beats clear
      if (rx_avail_q && !rd_data) begin
        overrun_q <= 1'b1;
      end else begin
        rx_data_q <= rx_shift_q[7:0];
        rx_nine_q <= rx_shift_q[8];
        rx_avail_q <= 1'b1;
        if (rd_data) overrun_q <= 1'b0;
      end
    end else if (rd_data) begin
      rx_avail_q <= 1'b0;
      overrun_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // wake-up and request flag
  // ---------------------------------------------------------------
  assign wake_set = rx_fall & FH_STOPPED
                  & ctrl2_q[ucbg_pkg::C2_RX_WAKE];
  assign irq_set =
    (ctrl2_q[ucbg_pkg::C2_RX_IRQ] & ((rx_avail_q & ~prev_avail_q) |
      (overrun_q & ~prev_ovr_q) | (wake_q & ~prev_wake_q))) |
    (ctrl2_q[ucbg_pkg::C2_TX_IDLE_IRQ] & tx_idle & ~prev_idle_q) |
    (ctrl2_q[ucbg_pkg::C2_TX_EMPTY_IRQ] & tx_empty & ~prev_empty_q);
  assign irq_clr = wr_stat & wdata_q[ucbg_pkg::ST_IRQ_REQ];
  assign IRQ_REQ = irq_q;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wake_q <= 1'b0;
      irq_q <= 1'b0;
      prev_idle_q <= 1'b1;
      prev_empty_q <= 1'b1;
      prev_avail_q <= 1'b0;
      prev_ovr_q <= 1'b0;
      prev_wake_q <= 1'b0;
    end else begin
      if (wake_set) wake_q <= 1'b1;
      else if (wr_stat && wdata_q[ucbg_pkg::ST_WAKE_REQ]) wake_q <= 1'b0;
      if (irq_set) irq_q <= 1'b1;
      else if (irq_clr) irq_q <= 1'b0;
      prev_idle_q <= tx_idle;
      prev_empty_q <= tx_empty;
      prev_avail_q <= rx_avail_q;
      prev_ovr_q <= overrun_q;
      prev_wake_q <= wake_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  chk_tx_floats: assert property (!tx_run |=> !TX_OE && TX_OUT)
    else $error("tx pin driven while transmitter disabled");
  chk_tx_drive: assert property (tx_run ##1 tx_run |-> TX_OE)
    else $error("tx pin not driven while enabled");
  chk_rx_abort: assert property (!rx_run |=>
      rx_state_q == ucbg_pkg::RX_IDLE && !rx_avail_q && !overrun_q)
    else $error("receiver not reset when disabled");
  chk_rx_owner: assert property (RX_ACTIVE == $past(rx_run))
    else $error("rx ownership does not follow enables");
  chk_baud_reload: assert property (tick
      |=> brg_cnt_q == $past(baud_div_q))
    else $error("baud counter did not reload");
  chk_baud_count: assert property (func_en && !FH_STOPPED &&
      brg_cnt_q != 8'h00 |=> brg_cnt_q == $past(brg_cnt_q) - 8'h01)
    else $error("baud counter did not count down");
  chk_bit_ticks: assert property (tx_state_q == ucbg_pkg::TX_START &&
      tx_end && tx_run ##1 tx_run |-> tx_state_q == ucbg_pkg::TX_DATA)
    else $error("start bit length wrong");
  chk_addr_keep: assert property (rx_run && rx_done && keep &&
      !rx_avail_q |=> rx_avail_q && rx_data_q == $past(rx_shift_q[7:0]))
    else $error("address word not delivered");
  chk_addr_drop: assert property (rx_run && rx_done && !keep &&
      !rx_avail_q && !irq_q |=> !rx_avail_q ##1 !irq_q)
    else $error("data word not discarded");
  chk_wake_cause: assert property ($rose(wake_q) |->
      $past(FH_STOPPED) && $past(ctrl2_q[ucbg_pkg::C2_RX_WAKE]))
    else $error("wake request without cause");
  chk_wake_run: assert property (!FH_STOPPED && !wake_q |=> !wake_q)
    else $error("wake request while fH runs");
  chk_wake_off: assert property (!ctrl2_q[ucbg_pkg::C2_RX_WAKE]
      && !wake_q |=> !wake_q)
    else $error("wake request while wake disabled");
  chk_irq_rx: assert property (ctrl2_q[ucbg_pkg::C2_RX_IRQ] &&
      $rose(rx_avail_q) |=> irq_q)
    else $error("rx data did not raise request");
  chk_irq_idle: assert property (ctrl2_q[ucbg_pkg::C2_TX_IDLE_IRQ] &&
      $rose(tx_idle) |=> irq_q)
    else $error("tx idle did not raise request");
  chk_irq_empty: assert property (ctrl2_q[ucbg_pkg::C2_TX_EMPTY_IRQ] &&
      $rose(tx_empty) |=> irq_q)
    else $error("tx empty did not raise request");
  chk_irq_quiet: assert property (ctrl2_q[2:0] == 3'h0 &&
      !irq_q |=> !irq_q)
    else $error("request set with all sources off");
  chk_func_off: assert property (!func_en |=>
      !ctrl2_q[ucbg_pkg::C2_TX_ENABLE] && !ctrl2_q[ucbg_pkg::C2_RX_ENABLE]
      && tx_empty && tx_idle)
    else $error("disable did not reset the function");

  cov_tx_frame: cover property (tx_state_q == ucbg_pkg::TX_STOP && tx_end);
  cov_rx_word: cover property ($rose(rx_avail_q));
  cov_overrun: cover property ($rose(overrun_q));
  cov_wake: cover property ($rose(wake_q) ##1 irq_q);
endmodule

/* File: ucbg_pkg.sv */
// constants of the serial control, data and baud generator block
package ucbg_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_LINE_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_SECOND = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA_BUF = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_BAUD_DIV = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LC_FUNC_ENABLE = 7;
  localparam int LC_NINE_BIT = 6;
  localparam int LC_RX_NINTH = 1;
  localparam int LC_TX_NINTH = 0;
  localparam int C2_TX_ENABLE = 7;
  localparam int C2_RX_ENABLE = 6;
  localparam int C2_HIGH_SPEED = 5;
  localparam int C2_ADDR_DETECT = 4;
  localparam int C2_RX_WAKE = 3;
  localparam int C2_RX_IRQ = 2;
  localparam int C2_TX_IDLE_IRQ = 1;
  localparam int C2_TX_EMPTY_IRQ = 0;
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_TX_IDLE = 1;
  localparam int ST_RX_AVAIL = 2;
  localparam int ST_RX_IDLE = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_WAKE_REQ = 5;
  localparam int ST_IRQ_REQ = 6;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] TICKS_LOW_SPEED = 7'h40;
  localparam logic [6:0] TICKS_HIGH_SPEED = 7'h10;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ucbg_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ucbg_rx_e;
endpackage

/* File: ucbg_remote.sv */
// remote serial node driving the receive line
module ucbg_remote (
  input wire logic clk,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // line idles high, as with a pull-up
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] b, input int bc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_line <= f[i];
      repeat (bc - 1) @(posedge clk);
    end
  endtask
endmodule

/* File: tb_ucbg_top.sv */
// testbench for the serial control and baud generator block
module tb_ucbg_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK, NRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TX_OUT, TX_OE;
  logic RX_IN, RX_ACTIVE, FH_STOPPED, IRQ_REQ;
  logic [ucbg_pkg::ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int err_count, compares, n;
  ucbg_top i_dut (.*);
  ucbg_remote i_remote (.clk(SYS_CLK), .rx_line(RX_IN));
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task end_of_test;
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tmo;
    err_count++;
    end_of_test;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID === 1'b1) break;
    end
    S_AXI_BREADY <= 1'b0;
    if (n == 50) tmo;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] r);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge SYS_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1) break;
    end
    S_AXI_RREADY <= 1'b0;
    if (n == 50) tmo;
    chk("read data", S_AXI_RDATA, {24'h000000, e});
    chk("read resp", {30'h0, S_AXI_RRESP}, {30'h0, r});
  endtask
  // length of the start bit in clocks; data bit 0 must be 1
  task bitlen(input int e);
    int c;
    c = 0;
    for (n = 0; n < 5000 && TX_OUT !== 1'b0; n++) @(posedge SYS_CLK);
    if (n == 5000) tmo;
    while (TX_OUT === 1'b0 && c < 5000) begin
      @(posedge SYS_CLK);
      c++;
    end
    chk("bit length", c, e);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    rd(ucbg_pkg::OFS_CTRL_SECOND, 8'h00, ucbg_pkg::RESP_OKAY);
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h3c);
    rd(ucbg_pkg::OFS_CTRL_SECOND, 8'h3c, ucbg_pkg::RESP_OKAY);
    rd(5'h14, 8'h00, ucbg_pkg::RESP_SLVERR);
  endtask
  task t_tx;
    wr(ucbg_pkg::OFS_BAUD_DIV, 8'h01);
    wr(ucbg_pkg::OFS_LINE_CTRL, 8'h80);
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h80);
    wr(ucbg_pkg::OFS_DATA_BUF, 8'h55);
    bitlen(128);
    chk("tx drive", {31'h0, TX_OE}, 32'h1);
    // abort in mid-frame
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h00);
    repeat (3) @(posedge SYS_CLK);
    chk("tx drive", {31'h0, TX_OE}, 32'h0);
    wr(ucbg_pkg::OFS_BAUD_DIV, 8'h02);
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'ha0);
    wr(ucbg_pkg::OFS_DATA_BUF, 8'h55);
    bitlen(48);
    repeat (150) @(posedge SYS_CLK);
  endtask
  task t_rx;
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h64);
    // let RX_ACTIVE follow the new receive enable before looking
    repeat (3) @(negedge SYS_CLK);
    chk("rx owned", {31'h0, RX_ACTIVE}, 32'h1);
    chk("irq", {31'h0, IRQ_REQ}, 32'h0);
    i_remote.send(8'ha5, 48);
    repeat (24) @(posedge SYS_CLK);
    chk("irq", {31'h0, IRQ_REQ}, 32'h1);
    rd(ucbg_pkg::OFS_DATA_BUF, 8'ha5, ucbg_pkg::RESP_OKAY);
    wr(ucbg_pkg::OFS_STATUS, 8'h40);
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h74);
    i_remote.send(8'h25, 48);
    repeat (24) @(posedge SYS_CLK);
    chk("irq", {31'h0, IRQ_REQ}, 32'h0);
    rd(ucbg_pkg::OFS_DATA_BUF, 8'ha5, ucbg_pkg::RESP_OKAY);
    i_remote.send(8'hc3, 48);
    repeat (24) @(posedge SYS_CLK);
    chk("irq", {31'h0, IRQ_REQ}, 32'h1);
    rd(ucbg_pkg::OFS_DATA_BUF, 8'hc3, ucbg_pkg::RESP_OKAY);
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h00);
    repeat (3) @(posedge SYS_CLK);
    chk("rx owned", {31'h0, RX_ACTIVE}, 32'h0);
  endtask
  task t_wake;
    FH_STOPPED <= 1'b1;
    wr(ucbg_pkg::OFS_STATUS, 8'h60);
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h04);
    i_remote.send(8'hff, 4);
    chk("irq", {31'h0, IRQ_REQ}, 32'h0);
    wr(ucbg_pkg::OFS_CTRL_SECOND, 8'h0c);
    i_remote.send(8'hff, 4);
    rd(ucbg_pkg::OFS_STATUS, 8'h6b, ucbg_pkg::RESP_OKAY);
    FH_STOPPED <= 1'b0;
    wr(ucbg_pkg::OFS_STATUS, 8'h60);
    i_remote.send(8'hff, 4);
    rd(ucbg_pkg::OFS_STATUS, 8'h0b, ucbg_pkg::RESP_OKAY);
  endtask
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = '0;
    {S_AXI_RREADY, FH_STOPPED, NRST, S_AXI_WDATA} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR} = '0;
    S_AXI_WSTRB = 4'hf;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge SYS_CLK);
    NRST <= 1'b1;
    t_regs;
    t_tx;
    t_rx;
    t_wake;
    end_of_test;
  end
endmodule
